// >>> core/e1ls_regs.vh
// Purpose: Constants for the E1 line error statistics block
// Assumes: 40 MHz sys_clk, event inputs are single-cycle strobes on sys_clk
// Notes on behaviour
// - Count bipolar violations only inside frames judged valid, throughout the test.
// - With HDB3 selected, substitution violations never count, nor spoil violation-free seconds.
// - Violation ratio is violation count over bits in valid frames.
// - Accumulate seconds without violations, out-of-sync seconds included; ratio over test seconds.
// - Count every individual error in received frame alignment signals.
// - Framing error ratio is framing errors over valid frames.
// - Count CRC-4 code word errors only while CRC-4 checking is enabled.
// - CRC-4 ratio is erroneous code words over code words received.
// - Count one sync loss per incident meeting resync criteria.
// - Sync loss ratio is sync losses over valid frames.
// - Accumulate out-of-sync time; ratio over test seconds.
// - Clean second needs no CRC, framing or violation error and sync throughout.
// - Leaving an error condition records its code into a four-entry history.
// - Show normal condition whenever no error condition is present on a monitored side; an unmonitored side shows unmonitored.
// - Flag far end frame alarm and store its own history code.
// - Flag distant superframe alarm and store its own history code.
// - Flag out-of-sync on resync criteria and store a sync-loss code.
// - No-signal since start, or signal lost 150 ms; both share one code.
// - Emulated side in normal transmit is unmonitored; drop-insert monitors both sides.
// - Reset command clears every timer and counter, test seconds included.
// - Count valid frames, 256 bits each, only frames judged valid.
// - Keep elapsed test seconds from zero at test start.
`ifndef E1LS_REGS_VH
`define E1LS_REGS_VH
`define E1LS_CLK_HZ         40000000
`define E1LS_SEC_CYCLES     (`E1LS_CLK_HZ)
`define E1LS_LOS_MS         150
`define E1LS_LOS_CYCLES     (`E1LS_CLK_HZ / 1000 * `E1LS_LOS_MS)
`define E1LS_BITS_PER_FRAME 256
`define E1LS_COND_NORMAL    3'h0
`define E1LS_COND_FAR_ALARM 3'h1
`define E1LS_COND_SUPER_ALM 3'h2
`define E1LS_COND_OUT_SYNC  3'h3
`define E1LS_COND_NO_SIGNAL 3'h4
`define E1LS_COND_SIG_LOST  3'h5
`define E1LS_COND_UNMON     3'h6
`define E1LS_HCODE_NONE     2'h0
`define E1LS_HCODE_FAR      2'h0
`define E1LS_HCODE_SUPER    2'h1
`define E1LS_HCODE_SYNC     2'h2
`define E1LS_HCODE_SIGNAL   2'h3
`endif

// >>> core/e1ls_side.v
// Purpose: One direction's counter set and line condition tracker
// Assumes: Events are one-cycle pulses on sys_clk; sec_tick from the shared divider
// Notes: Ratios are formed by software from these raw counts
`include "e1ls_regs.vh"
module e1ls_side #(
    parameter CW         = 32,
    parameter LOS_CYCLES = `E1LS_LOS_CYCLES
) (
    // Clock and reset
    input  wire          sys_clk,
    input  wire          reset_n,
    // Control
    input  wire          clear_cmd,
    input  wire          monitored,
    input  wire          hdb3_sel,
    input  wire          crc4_enable,
    input  wire          sec_tick,
    // Line events
    input  wire          valid_frame,
    input  wire          bipolar_violation,
    input  wire          hdb3_substitution,
    input  wire          fas_error,
    input  wire          crc4_word,
    input  wire          crc4_error,
    input  wire          resync_met,
    input  wire          in_sync,
    input  wire          signal_present,
    input  wire          far_end_frame_alarm,
    input  wire          distant_superframe_alarm,
    // Counters
    output reg  [CW-1:0] line_code_violation_count_ff,
    output reg  [CW-1:0] valid_bit_count_ff,
    output reg  [CW-1:0] violation_free_seconds_ff,
    output reg  [CW-1:0] framing_error_count_ff,
    output reg  [CW-1:0] valid_frame_count_ff,
    output reg  [CW-1:0] crc4_error_count_ff,
    output reg  [CW-1:0] crc4_word_count_ff,
    output reg  [CW-1:0] sync_loss_count_ff,
    output reg  [CW-1:0] out_of_sync_seconds_ff,
    output reg  [CW-1:0] clean_seconds_ff,
    // Condition
    output reg  [2:0]    condition_ff,
    output reg  [7:0]    history_ff,
    output reg  [2:0]    history_fill_ff
);
    localparam [CW-1:0] CMAX = {CW{1'b1}};
    localparam [CW-1:0] ONE  = {{(CW-1){1'b0}}, 1'b1};
    localparam [CW-1:0] BPF  = `E1LS_BITS_PER_FRAME;
    localparam [31:0]   LOSC = LOS_CYCLES;

    reg        viol_sec_ff;
    reg        err_sec_ff;
    reg        sync_bad_sec_ff;
    reg        seen_signal_ff;
    reg [31:0] loss_cnt_ff;
    reg [2:0]  nxt_condition;
    reg [1:0]  hcode;

    // Substitution violations are excluded when HDB3 is on
    wire real_bpv = monitored & bipolar_violation & ~(hdb3_sel & hdb3_substitution);
    wire bpv_in_frame = real_bpv & in_sync;

    function [CW-1:0] sat_add;
        input [CW-1:0] v;
        input [CW-1:0] d;
        reg   [CW:0]   s;
        begin
            s = {1'b0, v} + {1'b0, d};
            sat_add = s[CW] ? CMAX : s[CW-1:0];
        end
    endfunction

    // Counters, all saturating
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            line_code_violation_count_ff <= {CW{1'b0}};
            valid_bit_count_ff           <= {CW{1'b0}};
            violation_free_seconds_ff    <= {CW{1'b0}};
            framing_error_count_ff       <= {CW{1'b0}};
            valid_frame_count_ff         <= {CW{1'b0}};
            crc4_error_count_ff          <= {CW{1'b0}};
            crc4_word_count_ff           <= {CW{1'b0}};
            sync_loss_count_ff           <= {CW{1'b0}};
            out_of_sync_seconds_ff       <= {CW{1'b0}};
            clean_seconds_ff             <= {CW{1'b0}};
            viol_sec_ff                  <= 1'b0;
            err_sec_ff                   <= 1'b0;
            sync_bad_sec_ff              <= 1'b0;
        end else if (clear_cmd) begin
            line_code_violation_count_ff <= {CW{1'b0}};
            valid_bit_count_ff           <= {CW{1'b0}};
            violation_free_seconds_ff    <= {CW{1'b0}};
            framing_error_count_ff       <= {CW{1'b0}};
            valid_frame_count_ff         <= {CW{1'b0}};
            crc4_error_count_ff          <= {CW{1'b0}};
            crc4_word_count_ff           <= {CW{1'b0}};
            sync_loss_count_ff           <= {CW{1'b0}};
            out_of_sync_seconds_ff       <= {CW{1'b0}};
            clean_seconds_ff             <= {CW{1'b0}};
            viol_sec_ff                  <= 1'b0;
            err_sec_ff                   <= 1'b0;
            sync_bad_sec_ff              <= 1'b0;
        end else if (monitored) begin
            if (bpv_in_frame)
                line_code_violation_count_ff <= sat_add(line_code_violation_count_ff, ONE);
            if (valid_frame) begin
                valid_frame_count_ff <= sat_add(valid_frame_count_ff, ONE);
                valid_bit_count_ff   <= sat_add(valid_bit_count_ff, BPF);
            end
            if (fas_error)
                framing_error_count_ff <= sat_add(framing_error_count_ff, ONE);
            if (crc4_enable && crc4_error)
                crc4_error_count_ff <= sat_add(crc4_error_count_ff, ONE);
            if (crc4_enable && crc4_word)
                crc4_word_count_ff <= sat_add(crc4_word_count_ff, ONE);
            if (resync_met)
                sync_loss_count_ff <= sat_add(sync_loss_count_ff, ONE);
            if (sec_tick) begin
                if (!(viol_sec_ff || real_bpv))
                    violation_free_seconds_ff <= sat_add(violation_free_seconds_ff, ONE);
                if (sync_bad_sec_ff || !in_sync)
                    out_of_sync_seconds_ff <= sat_add(out_of_sync_seconds_ff, ONE);
                if (!(err_sec_ff || sync_bad_sec_ff || !in_sync || bpv_in_frame || fas_error
                      || (crc4_enable && crc4_error)))
                    clean_seconds_ff <= sat_add(clean_seconds_ff, ONE);
                viol_sec_ff     <= 1'b0;
                err_sec_ff      <= 1'b0;
                sync_bad_sec_ff <= 1'b0;
            end else begin
                viol_sec_ff     <= viol_sec_ff | real_bpv;
                err_sec_ff      <= err_sec_ff | bpv_in_frame | fas_error | (crc4_enable & crc4_error);
                sync_bad_sec_ff <= sync_bad_sec_ff | ~in_sync;
            end
        end
    end

    // Signal loss timing: 150 ms of silence before declaring loss
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            seen_signal_ff <= 1'b0;
            loss_cnt_ff    <= 32'h00000000;
        end else if (clear_cmd) begin
            seen_signal_ff <= 1'b0;
            loss_cnt_ff    <= 32'h00000000;
        end else if (signal_present) begin
            seen_signal_ff <= 1'b1;
            loss_cnt_ff    <= 32'h00000000;
        end else if (loss_cnt_ff < LOSC) begin
            loss_cnt_ff <= loss_cnt_ff + 32'h00000001;
        end
    end

    // Priority: signal, sync, far end alarm, superframe alarm
    always @* begin
        nxt_condition = `E1LS_COND_NORMAL;
        hcode         = `E1LS_HCODE_NONE;
        if (!monitored)
            nxt_condition = `E1LS_COND_UNMON;
        else if (!seen_signal_ff)
            nxt_condition = `E1LS_COND_NO_SIGNAL;
        else if (loss_cnt_ff >= LOSC)
            nxt_condition = `E1LS_COND_SIG_LOST;
        else if (!in_sync)
            nxt_condition = `E1LS_COND_OUT_SYNC;
        else if (far_end_frame_alarm)
            nxt_condition = `E1LS_COND_FAR_ALARM;
        else if (distant_superframe_alarm)
            nxt_condition = `E1LS_COND_SUPER_ALM;
        case (condition_ff)
            `E1LS_COND_FAR_ALARM: hcode = `E1LS_HCODE_FAR;
            `E1LS_COND_SUPER_ALM: hcode = `E1LS_HCODE_SUPER;
            `E1LS_COND_OUT_SYNC:  hcode = `E1LS_HCODE_SYNC;
            default:              hcode = `E1LS_HCODE_SIGNAL;
        endcase
    end

    // History is a shift register of the last four error conditions left
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            condition_ff    <= `E1LS_COND_NORMAL;
            history_ff      <= 8'h00;
            history_fill_ff <= 3'h0;
        end else if (clear_cmd) begin
            condition_ff    <= `E1LS_COND_NORMAL;
            history_ff      <= 8'h00;
            history_fill_ff <= 3'h0;
        end else begin
            condition_ff <= nxt_condition;
            if (nxt_condition != condition_ff && condition_ff != `E1LS_COND_NORMAL
                && condition_ff != `E1LS_COND_UNMON) begin
                history_ff <= {history_ff[5:0], hcode};
                if (history_fill_ff != 3'h4)
                    history_fill_ff <= history_fill_ff + 3'h1;
            end
        end
    end
endmodule

// >>> core/e1ls_top.v
// Purpose: E1 line error statistics for DTE and DCE directions
// Assumes: Line event strobes come from framer logic on sys_clk
// Notes: Counters saturate; software forms the ratios
`include "e1ls_regs.vh"
module e1ls_top #(
    parameter CW         = 32,
    parameter SEC_CYCLES = `E1LS_SEC_CYCLES,
    parameter LOS_CYCLES = `E1LS_LOS_CYCLES
) (
    // Clock and reset
    input  wire            sys_clk,
    input  wire            reset_n,
    // Control
    input  wire            clear_cmd,
    input  wire            hdb3_sel,
    input  wire            crc4_enable,
    input  wire            emulate_mode,
    input  wire            emulate_dce,
    input  wire            drop_insert_transmit,
    // Line events, index 0 DTE, 1 DCE
    input  wire [1:0]      valid_frame,
    input  wire [1:0]      bipolar_violation,
    input  wire [1:0]      hdb3_substitution,
    input  wire [1:0]      fas_error,
    input  wire [1:0]      crc4_word,
    input  wire [1:0]      crc4_error,
    input  wire [1:0]      resync_met,
    input  wire [1:0]      in_sync,
    input  wire [1:0]      signal_present,
    input  wire [1:0]      far_end_frame_alarm,
    input  wire [1:0]      distant_superframe_alarm,
    // Shared status
    output reg  [CW-1:0]   test_seconds_ff,
    output reg             sec_tick_ff,
    // Per side counters, DCE in upper half
    output wire [2*CW-1:0] line_code_violation_count,
    output wire [2*CW-1:0] valid_bit_count,
    output wire [2*CW-1:0] violation_free_seconds,
    output wire [2*CW-1:0] framing_error_count,
    output wire [2*CW-1:0] valid_frame_count,
    output wire [2*CW-1:0] crc4_error_count,
    output wire [2*CW-1:0] crc4_word_count,
    output wire [2*CW-1:0] sync_loss_count,
    output wire [2*CW-1:0] out_of_sync_seconds,
    output wire [2*CW-1:0] clean_seconds,
    output wire [5:0]      condition,
    output wire [15:0]     history,
    output wire [5:0]      history_fill
);
    localparam [31:0]   SECC = SEC_CYCLES;
    localparam [CW-1:0] CMAX = {CW{1'b1}};

    reg  [31:0] div_ff;
    reg  [1:0]  mon_ff;
    reg  [1:0]  nxt_mon;

    // One-second tick from the system clock
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_ff          <= 32'h00000000;
            sec_tick_ff     <= 1'b0;
            test_seconds_ff <= {CW{1'b0}};
        end else if (clear_cmd) begin
            div_ff          <= 32'h00000000;
            sec_tick_ff     <= 1'b0;
            test_seconds_ff <= {CW{1'b0}};
        end else begin
            sec_tick_ff <= (div_ff == SECC - 32'h00000001);
            div_ff      <= (div_ff == SECC - 32'h00000001) ? 32'h00000000 : div_ff + 32'h00000001;
            if (sec_tick_ff && test_seconds_ff != CMAX)
                test_seconds_ff <= test_seconds_ff + {{(CW-1){1'b0}}, 1'b1};
        end
    end

    // Emulated side goes unmonitored unless drop-and-insert is on
    always @* begin
        nxt_mon = 2'h3;
        if (emulate_mode && !drop_insert_transmit)
            nxt_mon[emulate_dce] = 1'b0;
    end

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            mon_ff <= 2'h3;
        else
            mon_ff <= nxt_mon;
    end

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : side
            e1ls_side #(
                .CW         (CW),
                .LOS_CYCLES (LOS_CYCLES)
            ) u_side (
                .sys_clk                      (sys_clk),
                .reset_n                      (reset_n),
                .clear_cmd                    (clear_cmd),
                .monitored                    (mon_ff[g]),
                .hdb3_sel                     (hdb3_sel),
                .crc4_enable                  (crc4_enable),
                .sec_tick                     (sec_tick_ff),
                .valid_frame                  (valid_frame[g]),
                .bipolar_violation            (bipolar_violation[g]),
                .hdb3_substitution            (hdb3_substitution[g]),
                .fas_error                    (fas_error[g]),
                .crc4_word                    (crc4_word[g]),
                .crc4_error                   (crc4_error[g]),
                .resync_met                   (resync_met[g]),
                .in_sync                      (in_sync[g]),
                .signal_present               (signal_present[g]),
                .far_end_frame_alarm          (far_end_frame_alarm[g]),
                .distant_superframe_alarm     (distant_superframe_alarm[g]),
                .line_code_violation_count_ff (line_code_violation_count[g*CW +: CW]),
                .valid_bit_count_ff           (valid_bit_count[g*CW +: CW]),
                .violation_free_seconds_ff    (violation_free_seconds[g*CW +: CW]),
                .framing_error_count_ff       (framing_error_count[g*CW +: CW]),
                .valid_frame_count_ff         (valid_frame_count[g*CW +: CW]),
                .crc4_error_count_ff          (crc4_error_count[g*CW +: CW]),
                .crc4_word_count_ff           (crc4_word_count[g*CW +: CW]),
                .sync_loss_count_ff           (sync_loss_count[g*CW +: CW]),
                .out_of_sync_seconds_ff       (out_of_sync_seconds[g*CW +: CW]),
                .clean_seconds_ff             (clean_seconds[g*CW +: CW]),
                .condition_ff                 (condition[g*3 +: 3]),
                .history_ff                   (history[g*8 +: 8]),
                .history_fill_ff              (history_fill[g*3 +: 3])
            );
        end
    endgenerate
endmodule

// >>> tb/e1ls_props.sv
// Purpose: Port-level timing checks on the E1 statistics block, DTE half
// Assumes: Bound into e1ls_top; the DCE half is built from the same side module
// Notes: Saturated counts are kept out of the frame, bit and violation step checks
module e1ls_props #(
    parameter CW         = 32,
    parameter SEC_CYCLES = 40000000
) (
    // Clock, reset and control
    input wire            sys_clk, reset_n, clear_cmd, hdb3_sel,
    input wire            emulate_mode, emulate_dce, drop_insert_transmit,
    // Line events
    input wire [1:0]      valid_frame, bipolar_violation, hdb3_substitution, in_sync,
    // Results
    input wire [CW-1:0]   test_seconds_ff,
    input wire            sec_tick_ff,
    input wire [2*CW-1:0] line_code_violation_count, valid_bit_count, valid_frame_count,
    input wire [5:0]      condition
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    reg           emu_ff;
    wire          live = !emu_ff && !clear_cmd;
    wire [CW-1:0] lcv0 = line_code_violation_count[CW-1:0];
    wire [CW-1:0] vbc0 = valid_bit_count[CW-1:0];
    wire [CW-1:0] vfc0 = valid_frame_count[CW-1:0];
    reg  [31:0]   gap_ff;
    reg           seen_ff;
    // A clear restarts the divider, so only tick-to-tick gaps are judged
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            gap_ff  <= 32'h0;
            seen_ff <= 1'b0;
        end else if (clear_cmd || sec_tick_ff) begin
            gap_ff  <= 32'h0;
            seen_ff <= !clear_cmd;
        end else begin
            gap_ff <= gap_ff + 32'h1;
        end
    end
    // Monitor enable is registered in the block, so the mirror lags one edge too
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            emu_ff <= 1'b0;
        else
            emu_ff <= emulate_mode && !emulate_dce && !drop_insert_transmit;
    end
    a_frame_step: assert property (live && valid_frame[0] && !(&vfc0)
        |=> vfc0 == $past(vfc0) + 1'b1) else $error("frame count did not step");
    a_bit_step: assert property (live && valid_frame[0] && 32'(vbc0) + 32'h100 <= 32'((1 << CW) - 1)
        |=> 32'(vbc0) == 32'($past(vbc0)) + 32'h100) else $error("bit count did not add a frame");
    a_bpv_count: assert property (live && bipolar_violation[0] && !hdb3_substitution[0] && in_sync[0]
        && !(&lcv0) |=> lcv0 == $past(lcv0) + 1'b1) else $error("violation not counted");
    a_subst_skip: assert property (hdb3_sel && bipolar_violation[0] && hdb3_substitution[0]
        && !clear_cmd |=> $stable(lcv0)) else $error("substitution violation counted");
    a_clear_all: assert property (clear_cmd |=> test_seconds_ff == '0 && lcv0 == '0
        && vfc0 == '0 && vbc0 == '0) else $error("clear left a count");
    a_tick_gap: assert property (sec_tick_ff && seen_ff |-> gap_ff == SEC_CYCLES - 1)
        else $error("second tick period wrong");
    a_sec_step: assert property (sec_tick_ff && !clear_cmd
        |=> test_seconds_ff == $past(test_seconds_ff) + 1'b1) else $error("test seconds did not step");
    a_unmon_cond: assert property (emu_ff && !clear_cmd
        |=> condition[2:0] == 3'h6) else $error("emulated side not unmonitored");
endmodule
bind e1ls_top e1ls_props #(.CW(CW), .SEC_CYCLES(SEC_CYCLES)) u_props (
    .sys_clk(sys_clk), .reset_n(reset_n), .clear_cmd(clear_cmd), .hdb3_sel(hdb3_sel),
    .emulate_mode(emulate_mode), .emulate_dce(emulate_dce), .drop_insert_transmit(drop_insert_transmit),
    .valid_frame(valid_frame), .bipolar_violation(bipolar_violation), .hdb3_substitution(hdb3_substitution),
    .in_sync(in_sync), .test_seconds_ff(test_seconds_ff), .sec_tick_ff(sec_tick_ff),
    .line_code_violation_count(line_code_violation_count), .valid_bit_count(valid_bit_count),
    .valid_frame_count(valid_frame_count), .condition(condition));

// >>> tb/e1ls_line.sv
// Purpose: Line model feeding framer strobes for both directions
// Assumes: A frame is shortened to 8 sys_clk cycles to keep runs short
// Notes: Outputs move 1 ns after the edge; a silent line drives zero on all but the bpv, sub, fas and ce event strobes
module e1ls_line (
    // Clock and bench commands
    input  wire        sys_clk,
    input  wire [1:0]  act, oos, far, sup,
    input  wire [2:0]  ev,
    input  wire        side,
    // Strobes and levels towards the block
    output logic [1:0] vf, bpv, sub, fas, cw, ce, rs, syn, sig, fa, sa
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] div_ff = 3'h0;
    logic [1:0] oos_ff = 2'h0;
    wire  [1:0] m      = side ? 2'h2 : 2'h1;
    wire  [1:0] run    = act & ~oos;
    initial {vf, bpv, sub, fas, cw, ce, rs, syn, sig, fa, sa} = 22'h0;
    always @(posedge sys_clk) begin
        div_ff <= div_ff + 3'h1;
        oos_ff <= oos & act;
        vf     <= #1 run & {2{div_ff == 3'h0}};
        cw     <= #1 run & {2{div_ff == 3'h0}};
        bpv    <= #1 m & {2{ev == 3'h1 || ev == 3'h2}};
        sub    <= #1 m & {2{ev == 3'h2}};
        fas    <= #1 m & {2{ev == 3'h3}};
        ce     <= #1 m & {2{ev == 3'h4}};
        rs     <= #1 oos & act & ~oos_ff;
        syn    <= #1 run;
        sig    <= #1 act;
        fa     <= #1 far & act;
        sa     <= #1 sup & act;
    end
endmodule

// >>> tb/tb_top.sv
// Purpose: Self-checking bench for the E1 line statistics block
// Assumes: Second and loss time shortened through parameters
// Notes: DTE carries the traffic; DCE is checked for separation
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam CW = 12;
    logic            sys_clk = 1'b0, reset_n = 1'b0, clear_cmd = 1'b0, hdb3_sel = 1'b0, crc4_enable = 1'b1;
    logic            emulate_mode = 1'b0, emulate_dce = 1'b0, drop_insert_transmit = 1'b0, side = 1'b0;
    logic [1:0]      act = 2'h0, oos = 2'h0, far = 2'h0, sup = 2'h0;
    logic [2:0]      ev = 3'h0;
    wire  [1:0]      vf, bpv, sub, fas, cw, ce, rs, syn, sig, fa, sa;
    wire  [CW-1:0]   tsec;
    wire             tick;
    wire  [2*CW-1:0] lcv, vbc, vfs, fec, vfc, cec, cwc, slc, oss, cls;
    wire  [5:0]      cond, fill;
    wire  [15:0]     hist;
    int              err_count = 0, n_checks = 0;
    always #12.5 sys_clk = ~sys_clk;
    e1ls_top #(.CW(CW), .SEC_CYCLES(100), .LOS_CYCLES(20)) DUT (
        .sys_clk(sys_clk), .reset_n(reset_n), .clear_cmd(clear_cmd), .hdb3_sel(hdb3_sel),
        .crc4_enable(crc4_enable), .emulate_mode(emulate_mode), .emulate_dce(emulate_dce),
        .drop_insert_transmit(drop_insert_transmit), .valid_frame(vf), .bipolar_violation(bpv),
        .hdb3_substitution(sub), .fas_error(fas), .crc4_word(cw), .crc4_error(ce), .resync_met(rs),
        .in_sync(syn), .signal_present(sig), .far_end_frame_alarm(fa), .distant_superframe_alarm(sa),
        .test_seconds_ff(tsec), .sec_tick_ff(tick), .line_code_violation_count(lcv),
        .valid_bit_count(vbc), .violation_free_seconds(vfs), .framing_error_count(fec),
        .valid_frame_count(vfc), .crc4_error_count(cec), .crc4_word_count(cwc),
        .sync_loss_count(slc), .out_of_sync_seconds(oss), .clean_seconds(cls), .condition(cond),
        .history(hist), .history_fill(fill));
    e1ls_line u_line (.sys_clk(sys_clk), .act(act), .oos(oos), .far(far), .sup(sup), .ev(ev), .side(side),
        .vf(vf), .bpv(bpv), .sub(sub), .fas(fas), .cw(cw), .ce(ce), .rs(rs), .syn(syn), .sig(sig), .fa(fa), .sa(sa));
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask
    task automatic pulse(input logic [2:0] code);
        ev = code;
        cyc(1);
        ev = 3'h0;
        cyc(3);
    endtask
    task automatic clr;
        clear_cmd = 1'b1;
        cyc(1);
        clear_cmd = 1'b0;
    endtask
    // Bounded wait that steps past the next second tick
    task automatic wt;
        for (int i = 0; i < 200 && tick !== 1'b1; i++) cyc(1);
        cyc(1);
    endtask
    task automatic t_frames;
        logic [CW-1:0] f0, b0, w0;
        act = 2'h1;
        clr;
        cyc(2);
        f0 = vfc[CW-1:0];
        b0 = vbc[CW-1:0];
        w0 = cwc[CW-1:0];
        cyc(80);
        chk(vfc[CW-1:0] - f0, 32'hA);
        chk(cwc[CW-1:0] - w0, 32'hA);
        chk(vbc[CW-1:0] - b0, 32'hA00);
        chk(vfc[2*CW-1:CW], 32'h0);
    endtask
    task automatic t_events;
        logic [CW-1:0] v, f, c, w;
        v = lcv[CW-1:0];
        f = fec[CW-1:0];
        c = cec[CW-1:0];
        pulse(3'h1);
        chk(lcv[CW-1:0], v + 32'h1);
        hdb3_sel = 1'b1;
        pulse(3'h2);
        chk(lcv[CW-1:0], v + 32'h1);
        hdb3_sel = 1'b0;
        pulse(3'h2);
        chk(lcv[CW-1:0], v + 32'h2);
        pulse(3'h3);
        chk(fec[CW-1:0], f + 32'h1);
        pulse(3'h4);
        chk(cec[CW-1:0], c + 32'h1);
        crc4_enable = 1'b0;
        w = cwc[CW-1:0];
        pulse(3'h4);
        cyc(16);
        chk(cec[CW-1:0], c + 32'h1);
        chk(cwc[CW-1:0], w);
        crc4_enable = 1'b1;
    endtask
    task automatic t_cond;
        logic [2:0]    cc [3] = '{3'h3, 3'h1, 3'h2};
        logic [1:0]    hc [3] = '{2'h2, 2'h0, 2'h1};
        logic [CW-1:0] s, v;
        s = slc[CW-1:0];
        v = lcv[CW-1:0];
        for (int i = 0; i < 3; i++) begin
            oos[0] = (i == 0);
            far[0] = (i == 1);
            sup[0] = (i == 2);
            pulse(3'h1);
            chk(cond[2:0], cc[i]);
            oos = 2'h0;
            far = 2'h0;
            sup = 2'h0;
            cyc(4);
            chk(hist[1:0], hc[i]);
        end
        chk(slc[CW-1:0], s + 32'h1);
        chk(lcv[CW-1:0], v + 32'h2);
        chk(fill[2:0], 32'h4);
        chk(hist[7:0], 32'hE1);
    endtask
    task automatic t_signal;
        act = 2'h0;
        cyc(12);
        chk(cond[2:0], 3'h3);
        cyc(18);
        chk(cond[2:0], 3'h5);
        act = 2'h1;
        cyc(4);
        chk(hist[1:0], 2'h3);
        emulate_mode = 1'b1;
        cyc(2);
        chk(cond[2:0], 3'h6);
        emulate_dce = 1'b1;
        cyc(2);
        chk(cond[5:3], 3'h6);
        drop_insert_transmit = 1'b1;
        cyc(2);
        chk(cond[2:0], 3'h0);
        emulate_mode = 1'b0;
        emulate_dce = 1'b0;
        drop_insert_transmit = 1'b0;
    endtask
    // Seconds: clean, violation, out of sync, clean
    task automatic t_seconds;
        clr;
        wt;
        pulse(3'h1);
        wt;
        oos = 2'h1;
        cyc(3);
        oos = 2'h0;
        wt;
        wt;
        cyc(3);
        chk(tsec, 32'h4);
        chk(vfs[CW-1:0], 32'h3);
        chk(oss[CW-1:0], 32'h1);
        chk(cls[CW-1:0], 32'h2);
    endtask
    task automatic t_sat;
        ev = 3'h1;
        cyc(4100);
        ev = 3'h0;
        cyc(3);
        chk(lcv[CW-1:0], 32'hFFF);
        clear_cmd = 1'b1;
        cyc(2);
        chk(lcv, 32'h0);
        chk(tsec, 32'h0);
        chk(fill, 32'h0);
        clear_cmd = 1'b0;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        cyc(5);
        reset_n = 1'b1;
        cyc(2);
        chk(cond, 32'h24);
        act = 2'h3;
        cyc(4);
        chk(cond, 32'h0);
        t_frames;
        t_events;
        t_cond;
        t_signal;
        t_seconds;
        t_sat;
        wrap_up;
    end
    initial begin
        #400us;
        err_count++;
        wrap_up;
    end
endmodule
